// ==== verilog/cbrf_regfile.sv ====
// Banked CPU register file with datapath ports and an Avalon-MM slave
// How it works
// - Four 16-bit data words serve as operands and results.
// - Data words zero and one each split into independent upper and lower bytes.
// - Words two over zero and three over one join into two 32-bit pairs.
// - Two 24-bit address registers act as data and supply indirect and relative bases.
// - A 24-bit static base register supplies the static-relative base.
// - A 24-bit frame base register supplies the frame-relative base.
// - A 24-bit instruction pointer holds the address of the instruction to run.
// - Data words, address registers and both bases exist in two full banks.
// - Flag word bit 4 routes datapath banked accesses to bank 0 when low, bank 1 when high.
// - A 24-bit user stack pointer and a 24-bit interrupt stack pointer are held.
// - Flag word bit 7 low picks the interrupt stack pointer, high the user one.
`timescale 1ns/100ps
`default_nettype none
`include "cbrf_defines.svh"
module cbrf_regfile
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] flagWord,
  input wire cbrf_pkg::cbrf_sel_t dpRdSel,
  output logic [31:0] dpRdData,
  input wire logic dpWrEn,
  input wire cbrf_pkg::cbrf_sel_t dpWrSel,
  input wire logic [31:0] dpWrData,
  output logic [23:0] addrFirstBase,
  output logic [23:0] addrSecondBase,
  output logic [23:0] staticBaseOut,
  output logic [23:0] frameBaseOut,
  output logic [23:0] instrPtrOut,
  output logic [23:0] stackPtrOut,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [1:0][3:0][15:0] bankDw;
  logic [1:0][1:0][23:0] bankAdr;
  logic [1:0][23:0] bankSb;
  logic [1:0][23:0] bankFb;
  logic [23:0] instrPtr;
  logic [23:0] userSp;
  logic [23:0] intSp;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (`CBRF_BANK_BIT > 15 || `CBRF_STACK_BIT > 15 || `CBRF_BANK_BIT == `CBRF_STACK_BIT)
  begin : g_bad_flags
    $error("bank and stack select bits must be distinct bits of the flag word");
  end

  // ----------------------------------------
  // Active bank and stack selection
  // ----------------------------------------
  wire logic bankFlag = flagWord[`CBRF_BANK_BIT];
  wire logic stackFlag = flagWord[`CBRF_STACK_BIT];
  wire logic [3:0][15:0] curDw = bankDw[bankFlag];
  wire logic [1:0][23:0] curAdr = bankAdr[bankFlag];
  wire logic [23:0] curSb = bankSb[bankFlag];
  wire logic [23:0] curFb = bankFb[bankFlag];
  wire logic [23:0] curSp = stackFlag ? userSp : intSp;

  function automatic logic isBanked(input cbrf_pkg::cbrf_sel_t s);
    return s <= cbrf_pkg::SEL_FBASE;
  endfunction

  function automatic logic [31:0] pick(input cbrf_pkg::cbrf_sel_t s,
                                       input logic [3:0][15:0] dw,
                                       input logic [1:0][23:0] ar,
                                       input logic [23:0] sb,
                                       input logic [23:0] fb);
    logic [31:0] r;
    r = 32'h00000000;
    case (s)
      cbrf_pkg::SEL_DW0: r = {16'h0000, dw[0]};
      cbrf_pkg::SEL_DW1: r = {16'h0000, dw[1]};
      cbrf_pkg::SEL_DW2: r = {16'h0000, dw[2]};
      cbrf_pkg::SEL_DW3: r = {16'h0000, dw[3]};
      cbrf_pkg::SEL_DW0U: r = {24'h000000, dw[0][15:8]};
      cbrf_pkg::SEL_DW0L: r = {24'h000000, dw[0][7:0]};
      cbrf_pkg::SEL_DW1U: r = {24'h000000, dw[1][15:8]};
      cbrf_pkg::SEL_DW1L: r = {24'h000000, dw[1][7:0]};
      cbrf_pkg::SEL_PAIRLO: r = {dw[2], dw[0]};
      cbrf_pkg::SEL_PAIRHI: r = {dw[3], dw[1]};
      cbrf_pkg::SEL_ADR0: r = {8'h00, ar[0]};
      cbrf_pkg::SEL_ADR1: r = {8'h00, ar[1]};
      cbrf_pkg::SEL_SBASE: r = {8'h00, sb};
      cbrf_pkg::SEL_FBASE: r = {8'h00, fb};
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Bus address decode
  // ----------------------------------------
  wire logic busInBank = avs_address[6] == 1'b0;
  wire logic busBank = avs_address[5];
  wire logic [2:0] busIdx = avs_address[4:2];
  wire cbrf_pkg::cbrf_sel_t busSel = (busIdx < 3'h4) ?
    cbrf_pkg::cbrf_sel_t'({2'b00, busIdx}) :
    cbrf_pkg::cbrf_sel_t'(5'h0a + {2'b00, busIdx} - 5'h04);
  wire logic [31:0] bankView = pick(busSel, bankDw[busBank], bankAdr[busBank],
                                    bankSb[busBank], bankFb[busBank]);
  wire logic [31:0] statusView = {14'h0000, stackFlag, bankFlag, flagWord};
  wire logic [31:0] busView =
    busInBank ? bankView :
    (avs_address == `CBRF_OFF_IPTR) ? {8'h00, instrPtr} :
    (avs_address == `CBRF_OFF_USP) ? {8'h00, userSp} :
    (avs_address == `CBRF_OFF_ISP) ? {8'h00, intSp} :
    (avs_address == `CBRF_OFF_STATUS) ? statusView : 32'h00000000;
  wire logic [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [31:0] busWrData = (busView & ~beMask) | (avs_writedata & beMask);
  wire logic busCommit = avs_write && !avs_waitrequest;
  wire logic [1:0] busBankWr = {busCommit && busInBank && busBank,
                                busCommit && busInBank && !busBank};
  wire logic [1:0] dpBankWr = {dpWrEn && isBanked(dpWrSel) && bankFlag,
                               dpWrEn && isBanked(dpWrSel) && !bankFlag};

  // ----------------------------------------
  // Two banks
  // ----------------------------------------
  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    cbrf_bank_store u_store
    (
      .core_clk(core_clk),
      .rst(rst),
      .aEn(busBankWr[b]),
      .aSel(busSel),
      .aData(busWrData),
      .bEn(dpBankWr[b]),
      .bSel(dpWrSel),
      .bData(dpWrData),
      .dataWord(bankDw[b]),
      .addrReg(bankAdr[b]),
      .staticBase(bankSb[b]),
      .frameBase(bankFb[b])
    );
  end

  // ----------------------------------------
  // Unbanked pointers, datapath wins
  // ----------------------------------------
  wire logic dpIptr = dpWrEn && dpWrSel == cbrf_pkg::SEL_IPTR;
  wire logic dpUsp = dpWrEn && (dpWrSel == cbrf_pkg::SEL_USP ||
                     (dpWrSel == cbrf_pkg::SEL_ASP && stackFlag));
  wire logic dpIsp = dpWrEn && (dpWrSel == cbrf_pkg::SEL_ISP ||
                     (dpWrSel == cbrf_pkg::SEL_ASP && !stackFlag));
  wire logic [23:0] next_instrPtr = dpIptr ? dpWrData[23:0] :
    (busCommit && avs_address == `CBRF_OFF_IPTR) ? busWrData[23:0] : instrPtr;
  wire logic [23:0] next_userSp = dpUsp ? dpWrData[23:0] :
    (busCommit && avs_address == `CBRF_OFF_USP) ? busWrData[23:0] : userSp;
  wire logic [23:0] next_intSp = dpIsp ? dpWrData[23:0] :
    (busCommit && avs_address == `CBRF_OFF_ISP) ? busWrData[23:0] : intSp;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      instrPtr <= `CBRF_RST_IPTR;
      userSp <= `CBRF_RST_ADDR;
      intSp <= `CBRF_RST_ADDR;
    end
    else
    begin
      instrPtr <= next_instrPtr;
      userSp <= next_userSp;
      intSp <= next_intSp;
    end
  end

  // ----------------------------------------
  // Datapath read and base outputs
  // ----------------------------------------
  wire logic [31:0] next_dpRdData =
    isBanked(dpRdSel) ? pick(dpRdSel, curDw, curAdr, curSb, curFb) :
    (dpRdSel == cbrf_pkg::SEL_IPTR) ? {8'h00, instrPtr} :
    (dpRdSel == cbrf_pkg::SEL_USP) ? {8'h00, userSp} :
    (dpRdSel == cbrf_pkg::SEL_ISP) ? {8'h00, intSp} :
    (dpRdSel == cbrf_pkg::SEL_ASP) ? {8'h00, curSp} : 32'h00000000;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dpRdData <= 32'h00000000;
      addrFirstBase <= `CBRF_RST_ADDR;
      addrSecondBase <= `CBRF_RST_ADDR;
      staticBaseOut <= `CBRF_RST_ADDR;
      frameBaseOut <= `CBRF_RST_ADDR;
      instrPtrOut <= `CBRF_RST_IPTR;
      stackPtrOut <= `CBRF_RST_ADDR;
    end
    else
    begin
      dpRdData <= next_dpRdData;
      addrFirstBase <= curAdr[0];
      addrSecondBase <= curAdr[1];
      staticBaseOut <= curSb;
      frameBaseOut <= curFb;
      instrPtrOut <= instrPtr;
      stackPtrOut <= curSp;
    end
  end

  // ----------------------------------------
  // Avalon-MM slave, one wait cycle
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? busView : avs_readdata;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  bus_wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  word_read_a: assert property (dpRdSel == cbrf_pkg::SEL_DW3
    |=> dpRdData == {16'h0000, $past(curDw[3])})
    else $error("data word read mismatch");
  byte_write_a: assert property (dpWrEn && dpWrSel == cbrf_pkg::SEL_DW0U
    && !bankFlag && !busBankWr[0]
    |=> bankDw[0][0] == {$past(dpWrData[7:0]), $past(bankDw[0][0][7:0])})
    else $error("upper byte write disturbed lower byte");
  pair_read_a: assert property (dpRdSel == cbrf_pkg::SEL_PAIRHI
    |=> dpRdData == $past({curDw[3], curDw[1]}))
    else $error("pair read order wrong");
  pair_keep_a: assert property (dpWrEn && dpWrSel == cbrf_pkg::SEL_PAIRLO
    && bankFlag && !busBankWr[1]
    |=> bankDw[1][1] == $past(bankDw[1][1]) && bankDw[1][3] == $past(bankDw[1][3]))
    else $error("pair write touched other pair");
  base_view_a: assert property (##1 addrSecondBase == $past(curAdr[1])
    && staticBaseOut == $past(curSb) && frameBaseOut == $past(curFb))
    else $error("base output lags wrongly");
  iptr_write_a: assert property (dpIptr
    |=> ##1 instrPtrOut == $past(dpWrData[23:0], 2))
    else $error("instruction pointer write lost");
  bank_isolate_a: assert property (dpWrEn && isBanked(dpWrSel) && bankFlag
    && !busBankWr[0] |=> $stable(bankDw[0]) && $stable(bankAdr[0]))
    else $error("inactive bank changed");
  stack_pick_a: assert property (##1 stackPtrOut ==
    ($past(stackFlag) ? $past(userSp) : $past(intSp)))
    else $error("wrong stack pointer active");
  bank_route_a: assert property (dpWrEn && dpWrSel == cbrf_pkg::SEL_ADR1
    && !bankFlag && !busBankWr[0]
    |=> bankAdr[0][1] == $past(dpWrData[23:0]))
    else $error("address register write went to wrong bank");
  sbase_write_a: assert property (dpWrEn && dpWrSel == cbrf_pkg::SEL_SBASE
    && bankFlag && !busBankWr[1]
    |=> bankSb[1] == $past(dpWrData[23:0]))
    else $error("static base write lost");
  low_byte_a: assert property (dpWrEn && dpWrSel == cbrf_pkg::SEL_DW1L
    && !bankFlag && !busBankWr[0]
    |=> bankDw[0][1] == {$past(bankDw[0][1][15:8]), $past(dpWrData[7:0])})
    else $error("lower byte write disturbed upper byte");
  asp_write_a: assert property (dpWrEn && dpWrSel == cbrf_pkg::SEL_ASP
    && stackFlag && !busCommit
    |=> userSp == $past(dpWrData[23:0]) && $stable(intSp))
    else $error("active stack pointer write went astray");
  usp_hold_a: assert property (!dpUsp
    && !(busCommit && avs_address == `CBRF_OFF_USP) |=> $stable(userSp))
    else $error("user stack pointer changed without a write");
  iptr_bus_a: assert property (busCommit && avs_address == `CBRF_OFF_IPTR && !dpIptr
    |=> instrPtr == $past(busWrData[23:0]))
    else $error("bus write to instruction pointer lost");
  read_stand_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved outside a read");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("wait request low while idle");

  bank_flip_c: cover property (!bankFlag ##1 bankFlag ##1 dpWrEn);
  bus_write_c: cover property (busCommit && busInBank);
  pair_write_c: cover property (dpWrEn && dpWrSel == cbrf_pkg::SEL_PAIRHI);
  bus_read_c: cover property (avs_read && !avs_waitrequest);
  user_stack_c: cover property (dpWrEn && dpWrSel == cbrf_pkg::SEL_ASP && stackFlag);
endmodule
`default_nettype wire

// ==== verilog/cbrf_defines.svh ====
// Offsets, field positions, widths and reset values of the register file
`ifndef CBRF_DEFINES_SVH
`define CBRF_DEFINES_SVH
`define CBRF_DATA_W 16
`define CBRF_ADDR_W 24
`define CBRF_BUS_AW 7
`define CBRF_BANK_BIT 4
`define CBRF_STACK_BIT 7
`define CBRF_BANK0_BASE 7'h00
`define CBRF_BANK1_BASE 7'h20
`define CBRF_OFF_IPTR 7'h40
`define CBRF_OFF_USP 7'h44
`define CBRF_OFF_ISP 7'h48
`define CBRF_OFF_STATUS 7'h4c
`define CBRF_RST_DATA 16'h0000
`define CBRF_RST_ADDR 24'h000000
`define CBRF_RST_IPTR 24'h000000
`endif

// ==== verilog/cbrf_pkg.sv ====
// Register selector codes shared by the register file modules
`default_nettype none
package cbrf_pkg;
  typedef enum logic [4:0]
  {
    SEL_DW0 = 5'h00,
    SEL_DW1 = 5'h01,
    SEL_DW2 = 5'h02,
    SEL_DW3 = 5'h03,
    SEL_DW0U = 5'h04,
    SEL_DW0L = 5'h05,
    SEL_DW1U = 5'h06,
    SEL_DW1L = 5'h07,
    SEL_PAIRLO = 5'h08,
    SEL_PAIRHI = 5'h09,
    SEL_ADR0 = 5'h0a,
    SEL_ADR1 = 5'h0b,
    SEL_SBASE = 5'h0c,
    SEL_FBASE = 5'h0d,
    SEL_IPTR = 5'h0e,
    SEL_USP = 5'h0f,
    SEL_ISP = 5'h10,
    SEL_ASP = 5'h11
  } cbrf_sel_t;
endpackage
`default_nettype wire

// ==== verilog/cbrf_bank_store.sv ====
// One bank of data, address and base registers with two write ports
`timescale 1ns/100ps
`default_nettype none
`include "cbrf_defines.svh"
module cbrf_bank_store
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic aEn,
  input wire cbrf_pkg::cbrf_sel_t aSel,
  input wire logic [31:0] aData,
  input wire logic bEn,
  input wire cbrf_pkg::cbrf_sel_t bSel,
  input wire logic [31:0] bData,
  output logic [3:0][15:0] dataWord,
  output logic [1:0][23:0] addrReg,
  output logic [23:0] staticBase,
  output logic [23:0] frameBase
);
  logic [3:0][15:0] next_dataWord;
  logic [1:0][23:0] next_addrReg;
  logic [23:0] next_staticBase;
  logic [23:0] next_frameBase;

  // ----------------------------------------
  // Write merge, port b applied last
  // ----------------------------------------
  always_comb
  begin
    next_dataWord = dataWord;
    next_addrReg = addrReg;
    next_staticBase = staticBase;
    next_frameBase = frameBase;
    for (int p = 0; p < 2; p++)
    begin
      automatic logic en = (p == 0) ? aEn : bEn;
      automatic cbrf_pkg::cbrf_sel_t sel = (p == 0) ? aSel : bSel;
      automatic logic [31:0] d = (p == 0) ? aData : bData;
      if (en)
      begin
        case (sel)
          cbrf_pkg::SEL_DW0: next_dataWord[0] = d[15:0];
          cbrf_pkg::SEL_DW1: next_dataWord[1] = d[15:0];
          cbrf_pkg::SEL_DW2: next_dataWord[2] = d[15:0];
          cbrf_pkg::SEL_DW3: next_dataWord[3] = d[15:0];
          cbrf_pkg::SEL_DW0U: next_dataWord[0][15:8] = d[7:0];
          cbrf_pkg::SEL_DW0L: next_dataWord[0][7:0] = d[7:0];
          cbrf_pkg::SEL_DW1U: next_dataWord[1][15:8] = d[7:0];
          cbrf_pkg::SEL_DW1L: next_dataWord[1][7:0] = d[7:0];
          cbrf_pkg::SEL_PAIRLO:
          begin
            next_dataWord[0] = d[15:0];
            next_dataWord[2] = d[31:16];
          end
          cbrf_pkg::SEL_PAIRHI:
          begin
            next_dataWord[1] = d[15:0];
            next_dataWord[3] = d[31:16];
          end
          cbrf_pkg::SEL_ADR0: next_addrReg[0] = d[23:0];
          cbrf_pkg::SEL_ADR1: next_addrReg[1] = d[23:0];
          cbrf_pkg::SEL_SBASE: next_staticBase = d[23:0];
          cbrf_pkg::SEL_FBASE: next_frameBase = d[23:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dataWord <= {4{`CBRF_RST_DATA}};
      addrReg <= {2{`CBRF_RST_ADDR}};
      staticBase <= `CBRF_RST_ADDR;
      frameBase <= `CBRF_RST_ADDR;
    end
    else
    begin
      dataWord <= next_dataWord;
      addrReg <= next_addrReg;
      staticBase <= next_staticBase;
      frameBase <= next_frameBase;
    end
  end
endmodule
`default_nettype wire

// ==== verification/cbrf_dp_model.sv ====
// Datapath model driving the flag word and the register file's datapath ports
`timescale 1ns/100ps
`default_nettype none
module cbrf_dp_model
(
  input wire logic core_clk,
  output var logic [15:0] flagWord,
  output var cbrf_pkg::cbrf_sel_t dpRdSel,
  input wire logic [31:0] dpRdData,
  output var logic dpWrEn,
  output var cbrf_pkg::cbrf_sel_t dpWrSel,
  output var logic [31:0] dpWrData
);
  initial
  begin
    flagWord = 16'h0000;
    dpRdSel = cbrf_pkg::SEL_DW0;
    dpWrEn = 1'b0;
    dpWrSel = cbrf_pkg::SEL_DW0;
    dpWrData = 32'h00000000;
  end
  task automatic set_flags(input logic [15:0] f);
    @(posedge core_clk);
    flagWord <= f;
  endtask
  task automatic dp_write(input cbrf_pkg::cbrf_sel_t sel, input logic [31:0] d);
    @(posedge core_clk);
    dpWrEn <= 1'b1;
    dpWrSel <= sel;
    dpWrData <= d;
    @(posedge core_clk);
    dpWrEn <= 1'b0;
    dpWrData <= ~d; // Idle data bus does not keep its last value
  endtask
  task automatic dp_read(input cbrf_pkg::cbrf_sel_t sel, output logic [31:0] d);
    @(posedge core_clk);
    dpRdSel <= sel;
    @(posedge core_clk);
    @(negedge core_clk);
    d = dpRdData;
  endtask
endmodule
`default_nettype wire

// ==== verification/cbrf_regfile_tb.sv ====
// Self-checking testbench of the banked register file
`timescale 1ns/100ps
`default_nettype none
module cbrf_regfile_tb;
  logic core_clk;
  logic rst;
  wire logic [15:0] flagWord;
  wire cbrf_pkg::cbrf_sel_t dpRdSel;
  wire cbrf_pkg::cbrf_sel_t dpWrSel;
  wire logic [31:0] dpRdData;
  wire logic dpWrEn;
  wire logic [31:0] dpWrData;
  wire logic [23:0] addrFirstBase;
  wire logic [23:0] addrSecondBase;
  wire logic [23:0] staticBaseOut;
  wire logic [23:0] frameBaseOut;
  wire logic [23:0] instrPtrOut;
  wire logic [23:0] stackPtrOut;
  logic [6:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  int fails;
  int checks;
  logic [31:0] rd;
  logic [31:0] t;
  logic [15:0] mw [4];
  cbrf_pkg::cbrf_sel_t selTab [8] = '{cbrf_pkg::SEL_DW0, cbrf_pkg::SEL_DW1, cbrf_pkg::SEL_DW2,
    cbrf_pkg::SEL_DW3, cbrf_pkg::SEL_ADR0, cbrf_pkg::SEL_ADR1, cbrf_pkg::SEL_SBASE,
    cbrf_pkg::SEL_FBASE};
  cbrf_pkg::cbrf_sel_t byteTab [4] = '{cbrf_pkg::SEL_DW0U, cbrf_pkg::SEL_DW0L,
    cbrf_pkg::SEL_DW1U, cbrf_pkg::SEL_DW1L};

  cbrf_regfile dut
  (
    .core_clk(core_clk), .rst(rst), .flagWord(flagWord), .dpRdSel(dpRdSel),
    .dpRdData(dpRdData), .dpWrEn(dpWrEn), .dpWrSel(dpWrSel), .dpWrData(dpWrData),
    .addrFirstBase(addrFirstBase), .addrSecondBase(addrSecondBase),
    .staticBaseOut(staticBaseOut), .frameBaseOut(frameBaseOut), .instrPtrOut(instrPtrOut),
    .stackPtrOut(stackPtrOut), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  cbrf_dp_model dpm
  (
    .core_clk(core_clk), .flagWord(flagWord), .dpRdSel(dpRdSel), .dpRdData(dpRdData),
    .dpWrEn(dpWrEn), .dpWrSel(dpWrSel), .dpWrData(dpWrData)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] regVal(input int b, input int i);
    logic [23:0] v;
    v = {8'h3c, 3'h0, 1'(b), 1'h0, 3'(i), 8'ha5};
    regVal = (i < 4) ? {16'h0000, v[15:0]} : {8'h00, v};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_xfer(input logic wr, input logic [6:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    #(50 * 4000);
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    avs_address = 7'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    dpm.dp_read(cbrf_pkg::SEL_DW3, rd);
    check(rd, 32'h00000000);
    bus_xfer(1'b0, 7'h20, 32'h0, 4'hf, rd);
    check(rd, 32'h00000000);
    $display("Test reset done");
    for (int b = 0; b < 2; b++)
    begin
      dpm.set_flags(b ? 16'h0010 : 16'h0000);
      for (int i = 0; i < 8; i++)
        dpm.dp_write(selTab[i], regVal(b, i) | 32'hee3c0000);
    end
    for (int b = 0; b < 2; b++)
    begin
      dpm.set_flags(b ? 16'h0010 : 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
        dpm.dp_read(selTab[i], rd);
        check(rd, regVal(b, i));
        bus_xfer(1'b0, 7'(b * 32 + i * 4), 32'h0, 4'hf, rd);
        check(rd, regVal(b, i));
      end
      check({8'h00, addrFirstBase}, regVal(b, 4));
      check({8'h00, addrSecondBase}, regVal(b, 5));
      check({8'h00, staticBaseOut}, regVal(b, 6));
      check({8'h00, frameBaseOut}, regVal(b, 7));
    end
    $display("Test banks done");
    dpm.set_flags(16'h0000);
    dpm.dp_write(cbrf_pkg::SEL_PAIRLO, 32'h87654321);
    dpm.dp_write(cbrf_pkg::SEL_PAIRHI, 32'hfedcba98);
    mw = '{16'h4321, 16'hba98, 16'h8765, 16'hfedc};
    for (int k = 0; k < 4; k++)
    begin
      dpm.dp_write(byteTab[k], {24'hffffff, 8'h90 + 8'(k)});
      if (k % 2 == 0)
        mw[k / 2][15:8] = 8'h90 + 8'(k);
      else
        mw[k / 2][7:0] = 8'h90 + 8'(k);
      dpm.dp_read(byteTab[k], rd);
      check(rd, {24'h000000, 8'h90 + 8'(k)});
    end
    for (int i = 0; i < 4; i++)
    begin
      dpm.dp_read(selTab[i], rd);
      check(rd, {16'h0000, mw[i]});
    end
    dpm.dp_read(cbrf_pkg::SEL_PAIRLO, rd);
    check(rd, {mw[2], mw[0]});
    dpm.dp_read(cbrf_pkg::SEL_PAIRHI, rd);
    check(rd, {mw[3], mw[1]});
    $display("Test halves and pairs done");
    dpm.dp_write(cbrf_pkg::SEL_IPTR, 32'hff123456);
    dpm.dp_write(cbrf_pkg::SEL_USP, 32'h00aaaa02);
    dpm.dp_write(cbrf_pkg::SEL_ISP, 32'h00bbbb04);
    dpm.dp_read(cbrf_pkg::SEL_ASP, rd);
    check(rd, 32'h00bbbb04);
    check({8'h00, stackPtrOut}, 32'h00bbbb04);
    check({8'h00, instrPtrOut}, 32'h00123456);
    dpm.set_flags(16'h0080);
    dpm.dp_read(cbrf_pkg::SEL_ASP, rd);
    check(rd, 32'h00aaaa02);
    check({8'h00, stackPtrOut}, 32'h00aaaa02);
    dpm.dp_write(cbrf_pkg::SEL_ASP, 32'h00cccc06);
    bus_xfer(1'b0, 7'h44, 32'h0, 4'hf, rd);
    check(rd, 32'h00cccc06);
    bus_xfer(1'b0, 7'h48, 32'h0, 4'hf, rd);
    check(rd, 32'h00bbbb04);
    bus_xfer(1'b0, 7'h40, 32'h0, 4'hf, rd);
    check(rd, 32'h00123456);
    bus_xfer(1'b1, 7'h48, 32'hffdddd08, 4'h3, rd);
    dpm.dp_read(cbrf_pkg::SEL_ISP, rd);
    check(rd, 32'h00bbdd08);
    dpm.dp_read(cbrf_pkg::SEL_USP, rd);
    check(rd, 32'h00cccc06);
    bus_xfer(1'b1, 7'h40, 32'h00654321, 4'hf, rd);
    bus_xfer(1'b0, 7'h40, 32'h0, 4'hf, rd);
    check(rd, 32'h00654321);
    check({8'h00, instrPtrOut}, 32'h00654321);
    $display("Test pointers done");
    bus_xfer(1'b1, 7'h04, 32'h1234beef, 4'hf, rd);
    dpm.set_flags(16'h0090);
    dpm.dp_read(cbrf_pkg::SEL_DW1, rd);
    check(rd, regVal(1, 1));
    dpm.dp_read(cbrf_pkg::SEL_DW1, rd);
    t = regVal(1, 1);
    bus_xfer(1'b1, 7'h24, 32'h11111177, 4'h1, rd);
    bus_xfer(1'b0, 7'h24, 32'h0, 4'hf, rd);
    check(rd, {16'h0000, t[15:8], 8'h77});
    bus_xfer(1'b0, 7'h04, 32'h0, 4'hf, rd);
    check(rd, 32'h0000beef);
    bus_xfer(1'b1, 7'h50, 32'h5555aaaa, 4'hf, rd);
    bus_xfer(1'b0, 7'h50, 32'h0, 4'hf, rd);
    check(rd, 32'h00000000);
    bus_xfer(1'b1, 7'h4c, 32'hffffffff, 4'hf, rd);
    bus_xfer(1'b0, 7'h4c, 32'h0, 4'hf, rd);
    check(rd, {14'h0000, 1'b1, 1'b1, 16'h0090});
    dpm.dp_read(cbrf_pkg::cbrf_sel_t'(5'h1f), rd);
    check(rd, 32'h00000000);
    dpm.set_flags(16'h0000);
    dpm.dp_write(cbrf_pkg::SEL_ASP, 32'h00eeee0a);
    bus_xfer(1'b0, 7'h48, 32'h0, 4'hf, rd);
    check(rd, 32'h00eeee0a);
    check({8'h00, stackPtrOut}, 32'h00eeee0a);
    $display("Test bus done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
